// [hw/flash_host_pkg.sv]
// package: command codes, locations and timing counts for the flash host controller
package flash_host_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam logic [14:0] CMD_ADDR_A      = 15'h5555;
    localparam logic [14:0] CMD_ADDR_B      = 15'h2aaa;
    localparam logic [7:0]  CODE_UNLOCK_1   = 8'haa;
    localparam logic [7:0]  CODE_UNLOCK_2   = 8'h55;
    localparam logic [7:0]  CODE_PROGRAM    = 8'ha0;
    localparam logic [7:0]  CODE_SETUP      = 8'h80;
    localparam logic [7:0]  CODE_ERASE      = 8'h10;
    localparam logic [7:0]  CODE_LOCKOUT    = 8'h40;
    localparam logic [7:0]  CODE_ID_ENTRY   = 8'h90;
    localparam logic [7:0]  CODE_ID_EXIT    = 8'hf0;
    localparam logic [7:0]  ERASED_BYTE     = 8'hff;
    localparam logic [17:0] ID_MAKER_ADDR   = 18'h00000;
    localparam logic [17:0] ID_PART_ADDR    = 18'h00001;
    localparam logic [17:0] ID_LOCK_ADDR    = 18'h00002;
    localparam int unsigned LOCKOUT_BIT_POS = 0;
    localparam int unsigned POLL_BIT_POS    = 7;
    localparam int unsigned ALT_BIT_POS     = 6;
    // times in their own units
    localparam int unsigned PROGRAM_MAX_US    = 50;
    localparam int unsigned ERASE_MAX_MS      = 1000;
    localparam int unsigned LOCKOUT_WAIT_MS   = 1000;
    localparam int unsigned ID_PAUSE_US       = 10;
    localparam int unsigned POWERUP_WRITE_MS  = 5;
    localparam int unsigned POWERUP_READ_US   = 100;
    // least waits and poll time limits in whole cycles; cycles per unit come from integer division, rounded down
    localparam int unsigned BYTE_PROGRAM_DURATION_CYC =
        (PROGRAM_MAX_US * (CLK_HZ / 1_000_000));
    localparam int unsigned ID_PAUSE_CYC = (ID_PAUSE_US * (CLK_HZ / 1_000_000));
    localparam int unsigned POWERUP_READ_DELAY_CYC =
        (POWERUP_READ_US * (CLK_HZ / 1_000_000));
    localparam int unsigned ERASE_DURATION_CYC = ERASE_MAX_MS * (CLK_HZ / 1000);
    localparam int unsigned LOCKOUT_WAIT_CYC   = LOCKOUT_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned POWERUP_WRITE_DELAY_CYC = POWERUP_WRITE_MS * (CLK_HZ / 1000);
    // pin strobe phases, in cycles of 100 ns (pulse and high widths >= 100 ns)
    localparam logic [1:0]  WE_LOW_CYC      = 2'd1;
    localparam logic [1:0]  WE_HIGH_CYC     = 2'd1;
    localparam logic [1:0]  RD_ACCESS_CYC   = 2'd2;
    localparam int unsigned CNT_W           = 27;
    localparam int unsigned POLL_LIMIT_W    = 27;
    typedef enum logic [2:0] {
        OP_READ    = 3'd0,
        OP_PROGRAM = 3'd1,
        OP_ERASE   = 3'd2,
        OP_LOCKOUT = 3'd3,
        OP_ID_ENTRY= 3'd4,
        OP_ID_EXIT = 3'd5,
        OP_ID_EXIT1= 3'd6
    } op_e;
endpackage

// [hw/flash_pin_cycle.sv]
// one bus cycle on the flash pins: a strobed write or an output-enabled read
`timescale 1ns/1ns
module flash_pin_cycle
    import flash_host_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        is_write,
    input  wire logic [17:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic [7:0]  dq_i,
    output logic             done,
    output logic [7:0]       rdata,
    output logic [17:0]      a_o,
    output logic [7:0]       dq_o,
    output logic             dq_oe,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n
);
    typedef enum logic [3:0] {
        PC_IDLE  = 4'b0001,
        PC_LOW   = 4'b0010,
        PC_HIGH  = 4'b0100,
        PC_DONE  = 4'b1000
    } pc_state_e;

    pc_state_e  state_reg;
    logic [1:0] cnt_reg;
    logic       wr_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= PC_IDLE;
            cnt_reg   <= 2'd0;
            wr_reg    <= 1'b0;
        end else begin
            unique case (state_reg)
                PC_IDLE: if (start) begin
                    state_reg <= PC_LOW;
                    wr_reg    <= is_write;
                    cnt_reg   <= is_write ? WE_LOW_CYC : RD_ACCESS_CYC;
                end
                PC_LOW: if (cnt_reg == 2'd1) begin
                    state_reg <= PC_HIGH;
                    cnt_reg   <= WE_HIGH_CYC;
                end else begin
                    cnt_reg <= cnt_reg - 2'd1;
                end
                PC_HIGH: if (cnt_reg == 2'd1) begin
                    state_reg <= PC_DONE;
                end else begin
                    cnt_reg <= cnt_reg - 2'd1;
                end
                PC_DONE: state_reg <= PC_IDLE;
                default: state_reg <= PC_IDLE;
            endcase
        end
    end

    // address and data held stable across the whole cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_o  <= 18'h00000;
            dq_o <= 8'h00;
        end else if (start && state_reg == PC_IDLE) begin
            a_o  <= addr;
            dq_o <= wdata;
        end
    end

    // read data captured at the end of the access time
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (state_reg == PC_LOW && !wr_reg && cnt_reg == 2'd1) begin
            rdata <= dq_i;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ce_n  <= 1'b1;
            oe_n  <= 1'b1;
            we_n  <= 1'b1;
            dq_oe <= 1'b0;
        end else begin
            ce_n  <= !(state_reg == PC_LOW || (start && state_reg == PC_IDLE));
            oe_n  <= !((state_reg == PC_LOW && !wr_reg) ||
                       (start && state_reg == PC_IDLE && !is_write));
            we_n  <= !(start && state_reg == PC_IDLE && is_write) &&
                     !(state_reg == PC_LOW && wr_reg && cnt_reg != 2'd1);
            dq_oe <= (start && state_reg == PC_IDLE && is_write) ||
                     ((state_reg == PC_LOW || state_reg == PC_HIGH) && wr_reg);
        end
    end

    assign done = (state_reg == PC_DONE);
endmodule

// [hw/flash_host_ctrl.sv]
// host controller issuing command sequences and waits to a parallel flash
//
// Behaviour
// - the fourth program write carries the target address and data byte.
// - chip erase is aa/5555, 55/2aaa, 80/5555, aa/5555, 55/2aaa, 10/5555 in order.
// - lockout set is the erase prefix ending in 40/5555, then the host waits 1 s.
// - identification entry is aa/5555, 55/2aaa, 90/5555, then a 10 us pause.
// - three-write identification exit is aa/5555, 55/2aaa, f0/5555, then a 10 us pause; the one-write exit (f0 at the request address) has no pause.
`timescale 1ns/1ns
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int unsigned ERASE_CYC   = ERASE_DURATION_CYC,
    parameter int unsigned LOCK_CYC    = LOCKOUT_WAIT_CYC,
    parameter int unsigned PU_WR_CYC   = POWERUP_WRITE_DELAY_CYC
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire logic [2:0]  req_op,
    input  wire logic [17:0] req_addr,
    input  wire logic [7:0]  req_data,
    output logic             req_ready,
    output logic             resp_valid,
    output logic [7:0]       resp_data,
    output logic             resp_timeout,
    output logic             id_mode,
    output logic [17:0]      a_o,
    output logic [7:0]       dq_o,
    output logic             dq_oe,
    input  wire logic [7:0]  dq_i,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n
);
    typedef enum logic [6:0] {
        S_POWERUP = 7'b0000001,
        S_IDLE    = 7'b0000010,
        S_ISSUE   = 7'b0000100,
        S_WAITCYC = 7'b0001000,
        S_POLL    = 7'b0010000,
        S_PAUSE   = 7'b0100000,
        S_RESP    = 7'b1000000
    } st_e;

    st_e              state_reg;
    op_e              op_reg;
    logic [2:0]       step_reg;
    logic [2:0]       nsteps;
    logic [17:0]      addr_reg;
    logic [7:0]       data_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] pu_cnt_reg;
    logic             wr_ok;
    logic             rd_ok;
    logic             timeout_reg;
    logic [7:0]       rd_prev_reg;
    logic             first_poll_reg;
    logic [17:0]      cyc_addr;
    logic [7:0]       cyc_data;
    logic             cyc_write;
    logic             cyc_start;
    logic             cyc_done;
    logic [7:0]       cyc_rdata;

    // ------------------------------------------------------------
    // power-up delays
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pu_cnt_reg <= '0;
        end else if (pu_cnt_reg < CNT_W'(PU_WR_CYC)) begin
            pu_cnt_reg <= pu_cnt_reg + 1'b1;
        end
    end
    assign wr_ok = (pu_cnt_reg >= CNT_W'(PU_WR_CYC));
    assign rd_ok = (pu_cnt_reg >= CNT_W'(POWERUP_READ_DELAY_CYC));

    // ------------------------------------------------------------
    // command sequence tables
    // ------------------------------------------------------------
    always_comb begin
        unique case (op_reg)
            OP_PROGRAM:  nsteps = 3'd4;
            OP_ERASE:    nsteps = 3'd6;
            OP_LOCKOUT:  nsteps = 3'd6;
            OP_ID_ENTRY: nsteps = 3'd3;
            OP_ID_EXIT:  nsteps = 3'd3;
            OP_ID_EXIT1: nsteps = 3'd1;
            default:     nsteps = 3'd1;
        endcase
    end

    // only the 15 low address bits take part in matching
    always_comb begin
        cyc_write = (op_reg != OP_READ);
        cyc_addr  = {3'b000, CMD_ADDR_A};
        cyc_data  = CODE_UNLOCK_1;
        if (op_reg == OP_READ) begin
            cyc_addr = addr_reg;
        end else if (op_reg == OP_ID_EXIT1) begin
            cyc_addr = addr_reg;
            cyc_data = CODE_ID_EXIT;
        end else begin
            unique case (step_reg)
                3'd0: cyc_data = CODE_UNLOCK_1;
                3'd1: begin
                    cyc_addr = {3'b000, CMD_ADDR_B};
                    cyc_data = CODE_UNLOCK_2;
                end
                3'd2: begin
                    unique case (op_reg)
                        OP_PROGRAM:  cyc_data = CODE_PROGRAM;
                        OP_ID_ENTRY: cyc_data = CODE_ID_ENTRY;
                        OP_ID_EXIT:  cyc_data = CODE_ID_EXIT;
                        default:     cyc_data = CODE_SETUP;
                    endcase
                end
                3'd3: begin
                    if (op_reg == OP_PROGRAM) begin
                        cyc_addr = addr_reg;
                        cyc_data = data_reg;
                    end
                end
                3'd4: begin
                    cyc_addr = {3'b000, CMD_ADDR_B};
                    cyc_data = CODE_UNLOCK_2;
                end
                default: cyc_data = (op_reg == OP_ERASE) ? CODE_ERASE : CODE_LOCKOUT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    assign cyc_start = (state_reg == S_ISSUE);
    assign req_ready = (state_reg == S_IDLE) && rd_ok;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg      <= S_POWERUP;
            op_reg         <= OP_READ;
            step_reg       <= 3'd0;
            addr_reg       <= 18'h00000;
            data_reg       <= 8'h00;
            cnt_reg        <= '0;
            timeout_reg    <= 1'b0;
            first_poll_reg <= 1'b0;
            rd_prev_reg    <= 8'h00;
        end else begin
            unique case (state_reg)
                S_POWERUP: if (rd_ok) state_reg <= S_IDLE;
                S_IDLE: if (req_valid && rd_ok) begin
                    // writes before the power-up delay would be dropped
                    if (op_e'(req_op) == OP_READ || wr_ok) begin
                        op_reg      <= op_e'(req_op);
                        addr_reg    <= req_addr;
                        data_reg    <= req_data;
                        step_reg    <= 3'd0;
                        timeout_reg <= 1'b0;
                        state_reg   <= S_ISSUE;
                    end
                end
                S_ISSUE: state_reg <= S_WAITCYC;
                S_WAITCYC: if (cyc_done) begin
                    // strokes follow back to back so nothing can break
                    if (op_reg != OP_READ && step_reg != nsteps - 3'd1) begin
                        step_reg  <= step_reg + 3'd1;
                        state_reg <= S_ISSUE;
                    end else begin
                        unique case (op_reg)
                            OP_PROGRAM: begin
                                cnt_reg        <= CNT_W'(BYTE_PROGRAM_DURATION_CYC);
                                first_poll_reg <= 1'b1;
                                state_reg      <= S_POLL;
                            end
                            OP_ERASE: begin
                                cnt_reg        <= CNT_W'(ERASE_CYC);
                                first_poll_reg <= 1'b1;
                                state_reg      <= S_POLL;
                            end
                            OP_LOCKOUT: begin
                                cnt_reg   <= CNT_W'(LOCK_CYC);
                                state_reg <= S_PAUSE;
                            end
                            OP_ID_ENTRY, OP_ID_EXIT: begin
                                cnt_reg   <= CNT_W'(ID_PAUSE_CYC);
                                state_reg <= S_PAUSE;
                            end
                            default: state_reg <= S_RESP;
                        endcase
                    end
                end
                S_POLL: begin
                    // toggle-bit polling: re-read target until bit 6 holds still and bit 7 shows the expected value
                    if (cnt_reg != '0) cnt_reg <= cnt_reg - 1'b1;
                    if (!first_poll_reg && cyc_done &&
                        cyc_rdata[ALT_BIT_POS] == rd_prev_reg[ALT_BIT_POS] &&
                        cyc_rdata[POLL_BIT_POS] == (op_reg == OP_ERASE ?
                            ERASED_BYTE[POLL_BIT_POS] : data_reg[POLL_BIT_POS])) begin
                        state_reg <= S_RESP;
                    end else if (cnt_reg == '0 && cyc_done) begin
                        // leave only with the pin idle, so no stale read ends the next request
                        timeout_reg <= 1'b1;
                        state_reg   <= S_RESP;
                    end
                    if (cyc_done) begin
                        rd_prev_reg    <= cyc_rdata;
                        first_poll_reg <= 1'b0;
                    end
                end
                S_PAUSE: begin
                    if (cnt_reg <= CNT_W'(1)) state_reg <= S_RESP;
                    else cnt_reg <= cnt_reg - 1'b1;
                end
                S_RESP: state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // identification mode tracking; maker/part/lockout reads use plain reads
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            id_mode <= 1'b0;
        end else if (state_reg == S_RESP) begin
            if (op_reg == OP_ID_ENTRY) id_mode <= 1'b1;
            else if (op_reg == OP_ID_EXIT || op_reg == OP_ID_EXIT1) id_mode <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resp_data    <= 8'h00;
            resp_timeout <= 1'b0;
        end else if (state_reg == S_RESP) begin
            resp_data    <= cyc_rdata;
            resp_timeout <= timeout_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) resp_valid <= 1'b0;
        else     resp_valid <= (state_reg == S_RESP);
    end

    // poll reads issued back to back at the target while busy
    logic poll_start;
    logic poll_busy_reg;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) poll_busy_reg <= 1'b0;
        else if (poll_start) poll_busy_reg <= 1'b1;
        else if (cyc_done) poll_busy_reg <= 1'b0;
    end
    assign poll_start = (state_reg == S_POLL) && !poll_busy_reg && !cyc_done;

    flash_pin_cycle u_cycle (
        .mclk     (mclk),
        .rst      (rst),
        .start    (cyc_start || poll_start),
        .is_write (cyc_start ? cyc_write : 1'b0),
        .addr     (cyc_start ? cyc_addr : addr_reg),
        .wdata    (cyc_data),
        .dq_i     (dq_i),
        .done     (cyc_done),
        .rdata    (cyc_rdata),
        .a_o      (a_o),
        .dq_o     (dq_o),
        .dq_oe    (dq_oe),
        .ce_n     (ce_n),
        .oe_n     (oe_n),
        .we_n     (we_n)
    );
endmodule

// [tb/flash_host_ctrl_props.sv]
// checker: pin order, strobes and waits of the flash host controller
`timescale 1ns/1ns
module flash_host_ctrl_chk
    import flash_host_pkg::*;
#(
    parameter int unsigned PU_WR_CYC = POWERUP_WRITE_DELAY_CYC
)
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        req_ready,
    input wire logic        id_mode,
    input wire logic [17:0] a_o,
    input wire logic [7:0]  dq_o,
    input wire logic        dq_oe,
    input wire logic        ce_n,
    input wire logic        oe_n,
    input wire logic        we_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [15:0] pu_cnt;
    logic [7:0]  pause_cnt;
    // ----
    // helper counters
    // ----
    always_ff @(posedge mclk or posedge rst)
        if (rst) pu_cnt <= 16'h0000;
        else if (pu_cnt != 16'hffff) pu_cnt <= pu_cnt + 16'h0001;
    always_ff @(posedge mclk or posedge rst)
        if (rst) pause_cnt <= 8'h00;
        else if (!we_n && a_o[14:0] == CMD_ADDR_A && (dq_o == CODE_ID_ENTRY || dq_o == CODE_ID_EXIT))
            pause_cnt <= 8'(ID_PAUSE_CYC);
        else if (pause_cnt != 8'h00) pause_cnt <= pause_cnt - 8'h01;
    // ----
    // properties
    // ----
    sequence s_wr(logic [14:0] ad, logic [7:0] d);
        !we_n && a_o[14:0] == ad && dq_o == d;
    endsequence
    chk_no_early_wr: assert property (pu_cnt < PU_WR_CYC |-> we_n)
        else $error("early write");
    chk_no_early_rd: assert property (pu_cnt < POWERUP_READ_DELAY_CYC - 2 |-> !req_ready && oe_n)
        else $error("early read");
    chk_unlock_pair: assert property (s_wr(CMD_ADDR_A, CODE_UNLOCK_1) |=> we_n[*2] ##[1:10] s_wr(CMD_ADDR_B, CODE_UNLOCK_2))
        else $error("unlock pair broken");
    chk_unlock_next: assert property (s_wr(CMD_ADDR_B, CODE_UNLOCK_2) |=> we_n[*2] ##[1:10] (!we_n && a_o[14:0] == CMD_ADDR_A))
        else $error("command location");
    chk_id_enter: assert property (s_wr(CMD_ADDR_A, CODE_ID_ENTRY) |-> ##[1:300] id_mode)
        else $error("id not entered");
    chk_id_leave: assert property (id_mode && !we_n && dq_o == CODE_ID_EXIT |-> ##[1:300] !id_mode)
        else $error("id not left");
    chk_id_pause: assert property (pause_cnt != 8'h00 |-> oe_n)
        else $error("read in id pause");
    chk_wr_strobe: assert property (!we_n |-> !ce_n && oe_n && dq_oe)
        else $error("bad write strobe");
    chk_rd_strobe: assert property (!oe_n |-> !ce_n && we_n && !dq_oe)
        else $error("bad read strobe");
endmodule
bind flash_host_ctrl flash_host_ctrl_chk #(.PU_WR_CYC(PU_WR_CYC)) chk_i (
    .mclk(mclk), .rst(rst), .req_ready(req_ready), .id_mode(id_mode), .a_o(a_o),
    .dq_o(dq_o), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));

// [tb/flash_dev_model.sv]
// behavioural flash device on the far side of the host controller pins
`timescale 1ns/1ns
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter int unsigned PU_WR      = 2000,
    parameter int unsigned PROG_CYC   = 20,
    parameter int unsigned SLOW_CYC   = 800,
    parameter int unsigned ERASE_CYC  = 100,
    parameter logic [7:0]  MAKER_CODE = 8'h3c,  // arbitrary value
    parameter logic [7:0]  PART_CODE  = 8'h5a   // arbitrary value
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic [17:0] a_o,
    input  wire logic [7:0]  dq_o,
    input  wire logic        dq_oe,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    output logic      [7:0]  dq_i
);
    logic [7:0]  mem [bit [17:0]];
    logic [7:0]  rd_val, wd, pbyte, last_q = 8'h00;
    logic [17:0] wa;
    logic        id, we_q, oe_q, lock = 1'b0, tog = 1'b0;
    int          st, busy, pu;
    // released bus shows the inverse of its last level, never stale data
    assign dq_i = dq_oe ? dq_o : (!ce_n && !oe_n && pu >= POWERUP_READ_DELAY_CYC) ? rd_val : ~last_q;
    always @* begin
        if (busy != 0)
            rd_val = {~pbyte[7], tog, pbyte[5:0]};
        else if (id && a_o[17:2] == 16'h0000)
            rd_val = a_o[1] ? {7'h00, lock} : (a_o[0] ? PART_CODE : MAKER_CODE);
        else
            rd_val = mem.exists(a_o) ? mem[a_o] : ERASED_BYTE;
    end
    task automatic wr(input logic [17:0] ad, input logic [7:0] d);
        logic ca, cb;
        ca = (ad[14:0] == CMD_ADDR_A);
        cb = (ad[14:0] == CMD_ADDR_B);
        if (st == 6) begin
            if (!(lock && ad < 18'h02000))
                mem[ad] = (mem.exists(ad) ? mem[ad] : ERASED_BYTE) & d;
            pbyte = d;
            busy = slow ? SLOW_CYC : PROG_CYC;
            st = 0;
        end else if (d == CODE_ID_EXIT && (st == 0 || (st == 2 && ca))) begin
            id = 1'b0;
            st = 0;
        end else if (st == 0 || st == 3)
            st = (ca && d == CODE_UNLOCK_1) ? st + 1 : 0;
        else if (st == 1 || st == 4)
            st = (cb && d == CODE_UNLOCK_2) ? st + 1 : 0;
        else if (st == 2 && ca && d == CODE_PROGRAM)
            st = 6;
        else if (st == 2 && ca && d == CODE_SETUP)
            st = 3;
        else begin
            if (st == 2 && ca && d == CODE_ID_ENTRY) id = 1'b1;
            if (st == 5 && ca && d == CODE_LOCKOUT) lock = 1'b1;
            if (st == 5 && ca && d == CODE_ERASE) begin
                if (!lock)
                    mem.delete();
                else
                    foreach (mem[k])
                        if (k >= 18'h02000) mem[k] = ERASED_BYTE;
                pbyte = ERASED_BYTE;
                busy = ERASE_CYC;
            end
            st = 0;
        end
    endtask
    always @(negedge mclk or posedge rst) begin
        if (rst) begin
            id = 1'b0;
            st = 0;
            busy = 0;
            pu = 0;
            we_q = 1'b1;
            oe_q = 1'b1;
        end else begin
            if (busy != 0) busy = busy - 1;
            if (!we_q && we_n && pu >= PU_WR && busy == 0) wr(wa, wd);
            if (!oe_q && oe_n) tog = ~tog;
            if (!we_n && !ce_n) begin
                wa = a_o;
                wd = dq_o;
            end
            if (pu < PU_WR) pu = pu + 1;
            we_q = we_n;
            oe_q = oe_n;
            last_q = dq_i;
        end
    end
endmodule

// [tb/flash_host_ctrl_tb.sv]
// self-checking bench: host controller driving a behavioural flash device
`timescale 1ns/1ns
module flash_host_ctrl_tb import flash_host_pkg::*;;
    localparam int unsigned PU_WR = 2000;
    logic        mclk, rst, req_valid, req_ready, resp_valid, resp_timeout, id_mode;
    logic [2:0]  req_op;
    logic [17:0] req_addr, a_o;
    logic [7:0]  req_data, resp_data, dq_o, dq_i, r1;
    logic        dq_oe, ce_n, oe_n, we_n, slow;
    int          num_errors = 0, comparisons = 0, cyc;
    flash_host_ctrl #(.ERASE_CYC(200), .LOCK_CYC(200), .PU_WR_CYC(PU_WR)) uut (
        .mclk(mclk), .rst(rst), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
        .req_data(req_data), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_timeout(resp_timeout), .id_mode(id_mode), .a_o(a_o),
        .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
    flash_dev_model #(.PU_WR(PU_WR)) dev (
        .mclk(mclk), .rst(rst), .slow(slow), .a_o(a_o), .dq_o(dq_o), .dq_oe(dq_oe),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_i(dq_i));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk or posedge rst)
        if (rst) cyc <= 0;
        else cyc <= cyc + 1;
    // ----
    // shared tasks
    // ----
    task automatic expect8(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic do_req(input op_e op, input logic [17:0] ad, input logic [7:0] d);
        int n = 0;
        @(negedge mclk);
        req_valid = 1'b1;
        req_op = op;
        req_addr = ad;
        req_data = d;
        while (req_ready !== 1'b1 && n < 5000) begin @(negedge mclk); n++; end
        while (req_ready !== 1'b0 && n < 9000) begin @(negedge mclk); n++; end
        req_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 20000) begin @(negedge mclk); n++; end
        if (n >= 20000) expect8(8'h00, 8'h01, "answer");
    endtask
    task automatic rd(input logic [17:0] ad, input logic [7:0] exp);
        do_req(OP_READ, ad, 8'h00);
        expect8(resp_data, exp, "read data");
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_powerup();
        int n = 0;
        while (req_ready !== 1'b1 && n < 3000) begin @(negedge mclk); n++; end
        expect8(8'(n >= POWERUP_READ_DELAY_CYC - 3 && n <= POWERUP_READ_DELAY_CYC + 5), 8'h01, "ready delay");
        do_req(OP_PROGRAM, 18'h00100, 8'h5a);
        expect8(8'(cyc >= PU_WR), 8'h01, "write delay");
        rd(18'h00100, 8'h5a);
    endtask
    task automatic t_program();
        do_req(OP_PROGRAM, 18'h34123, 8'h81);
        expect8({7'h00, resp_timeout}, 8'h00, "program finished");
        expect8(resp_data, 8'h81, "last poll read");
        rd(18'h34123, 8'h81);
        slow = 1'b1;
        do_req(OP_PROGRAM, 18'h20040, 8'h3c);
        slow = 1'b0;
        expect8({7'h00, resp_timeout}, 8'h01, "slow timeout");
        do_req(OP_READ, 18'h20040, 8'h00);
        expect8(resp_data & 8'hbf, 8'hbc, "busy poll bit");
        r1 = resp_data;
        do_req(OP_READ, 18'h20040, 8'h00);
        expect8((resp_data ^ r1) & 8'h40, 8'h40, "toggle");
        repeat (900) @(negedge mclk);
        rd(18'h20040, 8'h3c);
    endtask
    task automatic t_erase();
        do_req(OP_ERASE, 18'h00000, 8'h00);
        expect8({7'h00, resp_timeout}, 8'h00, "erase finished");
        rd(18'h00100, ERASED_BYTE);
        rd(18'h34123, ERASED_BYTE);
    endtask
    task automatic t_id();
        do_req(OP_ID_ENTRY, 18'h00000, 8'h00);
        expect8({7'h00, id_mode}, 8'h01, "id mode set");
        rd(18'h00000, 8'h3c);
        rd(18'h00001, 8'h5a);
        rd(ID_LOCK_ADDR, 8'h00);
        do_req(OP_ID_EXIT, 18'h00000, 8'h00);
        expect8({7'h00, id_mode}, 8'h00, "id mode cleared");
        rd(18'h00000, ERASED_BYTE);
        do_req(OP_ID_ENTRY, 18'h00000, 8'h00);
        do_req(OP_ID_EXIT1, 18'h01234, CODE_ID_EXIT);
        rd(18'h00000, ERASED_BYTE);
    endtask
    task automatic t_lock();
        do_req(OP_PROGRAM, 18'h00010, 8'h00);
        do_req(OP_PROGRAM, 18'h24010, 8'h00);
        do_req(OP_LOCKOUT, 18'h00000, 8'h00);
        do_req(OP_ID_ENTRY, 18'h00000, 8'h00);
        rd(ID_LOCK_ADDR, 8'h01);
        do_req(OP_ID_EXIT1, 18'h00000, CODE_ID_EXIT);
        do_req(OP_ERASE, 18'h00000, 8'h00);
        rd(18'h00010, 8'h00);
        rd(18'h24010, ERASED_BYTE);
    endtask
    task automatic t_power_loss();
        do_req(OP_ID_ENTRY, 18'h00000, 8'h00);
        @(negedge mclk);
        rst = 1'b1;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        expect8({7'h00, id_mode}, 8'h00, "id after reset");
        rd(18'h00000, ERASED_BYTE);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_op = 3'h0;
        req_addr = 18'h00000;
        req_data = 8'h00;
        slow = 1'b0;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        t_powerup();
        t_program();
        t_erase();
        t_id();
        t_lock();
        t_power_loss();
        wrap_up();
    end
endmodule
